// ===== diag_record_defs.vh
// Constants of the diagnostic data record of a four-channel analog input.
// Assumes a 10 MHz system clock; included by the record only, not by its storage.
`ifndef DIAG_RECORD_DEFS_VH
`define DIAG_RECORD_DEFS_VH

// ---------------------------------------------------------------------
// Access selectors
// ---------------------------------------------------------------------
`define REC_SET_FIRST4 8'h00
`define REC_SET_FULL 8'h01
`define OBJ_INDEX_FIRST4 16'h2F00
`define OBJ_INDEX_FULL 16'h2F01
`define OBJ_INDEX_SUB 16'h5005
`define SUBIDX_FIRST 8'h02
`define SUBIDX_TIMESTAMP 8'h13
`define RECORD_BYTES 5'd20
`define FIRST4_BYTES 5'd4
`define TS_BYTE_POS 5'd16

// ---------------------------------------------------------------------
// Byte positions in the record
// ---------------------------------------------------------------------
`define BYTE_SUMMARY_FIRST 5'd0
`define BYTE_MODULE_INFO 5'd1
`define BYTE_RESERVED_C 5'd2
`define BYTE_SUMMARY_INT 5'd3
`define BYTE_CHANNEL_KIND 5'd4
`define BYTE_BITS_PER_CH 5'd5
`define BYTE_CHANNEL_COUNT 5'd6
`define BYTE_GROUP_ERRORS 5'd7
`define BYTE_CH0_FAULT 5'd8

// ---------------------------------------------------------------------
// Constant contents and field positions
// ---------------------------------------------------------------------
`define MODULE_CLASS_ANALOG 4'h5
`define MODULE_INFO_VAL 8'h15
`define CHANNEL_KIND_AI 8'h71
`define BITS_PER_CH_VAL 8'h08
`define CHANNEL_COUNT_VAL 8'h04
`define INT_BUF_OVF_BIT 3
`define INT_COMM_ERR_BIT 4
`define CH_PARAM_ERR_BIT 0
`define CH_UNDER_BIT 6
`define CH_OVER_BIT 7

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define CLK_FREQ_HZ 10000000
`define TICK_PERIOD_US 1
`define TICK_CYCLES (`CLK_FREQ_HZ / 1000000 * `TICK_PERIOD_US)

`endif

// ===== diag_byte_store.v
// Small register-backed store of record bytes 0 to 7 (summaries, constants and group errors).
// Assumes one writer at a time and a registered, one-cycle read.
`timescale 1ns/1ps
`default_nettype none

module diag_byte_store #(
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Write side
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  // Read side
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data_r
);

  reg [7:0] mem [0:DEPTH-1];
  integer i;

  // Storage is cleared at reset so every byte reads 00h first.
  always @(posedge clk) begin
    if (!rst_b) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= 8'h00;
      end
      rd_data_r <= 8'h00;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ===== analog_input_diagnostic_record.v
// Read-only diagnostic record of a four-channel analog input module.
// Assumes the backplane coupler presents synchronous read requests.
//
// Functional notes
// - Channel error lights LED and is recorded.
// - No diagnostic interrupt; readout only.
// - Record set 01h full, 00h first four.
// - Index 2F01h full, 2F00h first four.
// - Index 5005h reads each group by subindex.
// - Module information reads 15h, analog class.
// - Summary bit 3 flags diagnostics buffer overflow.
// - Summary bit 4 flags internal communication error.
// - Channel kind reads 71h, analog input.
// - Bits per channel reads 08h.
// - Channel count reads 04h.
// - Group error bit n per channel n.
// - Fault bit 0 parameter assignment error.
// - Fault bit 6 measuring range underflow.
// - Fault bit 7 measuring range overflow.
// - Timestamp captures microsecond timer at recording.
// - Microsecond timer starts at zero, wraps.
`include "diag_record_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module analog_input_diagnostic_record #(
  parameter CHANNELS = 4,
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Channel error sources, one bit per channel
  input wire [CHANNELS-1:0] param_error,
  input wire [CHANNELS-1:0] range_underflow,
  input wire [CHANNELS-1:0] range_overflow,
  // Internal fault sources
  input wire int_buffer_overflow,
  input wire int_comm_error,
  // Indicators
  output reg [CHANNELS-1:0] channel_led_r,
  output reg module_error_led_r,
  output wire diag_irq,
  // Backplane read request
  input wire rd_req,
  input wire [1:0] rd_mode,
  input wire [7:0] record_set_number,
  input wire [15:0] object_index,
  input wire [7:0] object_subindex,
  input wire [4:0] rd_byte,
  // Backplane read answer
  output reg rd_valid_r,
  output reg rd_error_r,
  output reg [31:0] rd_data_r,
  output reg [4:0] rd_len_r,
  // Free-running timer view
  output wire [31:0] us_timer
);

  // -------------------------------------------------------------------
  // Access modes
  // -------------------------------------------------------------------
  localparam [1:0] MODE_RECSET = 2'h0;
  localparam [1:0] MODE_INDEX = 2'h1;
  localparam [1:0] MODE_SUBIDX = 2'h2;

  // The answer side rests one cycle after each taken request.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;

  // -------------------------------------------------------------------
  // Microsecond timer
  // -------------------------------------------------------------------
  // The divider gives one step of the timer per microsecond.
  localparam integer TICK_LAST = TICK_CYCLES - 1;
  reg [7:0] tick_cnt_r;
  reg [31:0] us_cnt_r;
  wire [7:0] tick_end = TICK_LAST[7:0];
  wire tick = (tick_cnt_r == tick_end);

  always @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt_r <= 8'h00;
      us_cnt_r <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
      // The 32-bit count wraps to zero by itself.
      if (tick) begin
        us_cnt_r <= us_cnt_r + 32'h00000001;
      end
    end
  end
  assign us_timer = us_cnt_r;

  // -------------------------------------------------------------------
  // Channel fault bytes and summaries
  // -------------------------------------------------------------------
  wire [8*CHANNELS-1:0] fault_now;
  wire [CHANNELS-1:0] group_err;
  // Each channel byte holds its three fault bits; bits 5 to 1 read zero.
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : gen_ch
      assign fault_now[8*g+`CH_PARAM_ERR_BIT] = param_error[g];
      assign fault_now[8*g+5:8*g+1] = 5'h00;
      assign fault_now[8*g+`CH_UNDER_BIT] = range_underflow[g];
      assign fault_now[8*g+`CH_OVER_BIT] = range_overflow[g];
      assign group_err[g] = param_error[g] | range_underflow[g] |
        range_overflow[g];
    end
  endgenerate

  reg [8*CHANNELS-1:0] fault_r;
  reg [7:0] group_r;
  reg [7:0] internal_r;
  reg [31:0] stamp_r;
  wire [7:0] internal_nxt;
  assign internal_nxt[2:0] = 3'h0;
  assign internal_nxt[`INT_BUF_OVF_BIT] = int_buffer_overflow;
  assign internal_nxt[`INT_COMM_ERR_BIT] = int_comm_error;
  assign internal_nxt[7:5] = 3'h0;
  // Any change of a fault byte or of the internal byte is a new event.
  wire event_now = (fault_now != fault_r) || (internal_nxt != internal_r);

  always @(posedge clk) begin
    if (!rst_b) begin
      fault_r <= {8*CHANNELS{1'b0}};
      group_r <= 8'h00;
      internal_r <= 8'h00;
      stamp_r <= 32'h00000000;
    end else begin
      fault_r <= fault_now;
      group_r <= {{(8-CHANNELS){1'b0}}, group_err};
      internal_r <= internal_nxt;
      if (event_now) begin
        stamp_r <= us_cnt_r;
      end
    end
  end

  // -------------------------------------------------------------------
  // Indicators
  // -------------------------------------------------------------------
  // A channel lamp lights one cycle after any fault of its channel.
  always @(posedge clk) begin
    if (!rst_b) begin
      channel_led_r <= {CHANNELS{1'b0}};
      module_error_led_r <= 1'b0;
    end else begin
      channel_led_r <= group_err;
      module_error_led_r <= (|group_err) | int_buffer_overflow |
        int_comm_error;
    end
  end

  // Diagnostics are only read out, never signalled.
  assign diag_irq = 1'b0;

  // -------------------------------------------------------------------
  // Record byte mux
  // -------------------------------------------------------------------
  // Returns the record byte at a position from the registered state.
  function [7:0] rec_byte;
    input [4:0] pos;
    input [8*CHANNELS-1:0] faults;
    input [7:0] grp;
    input [7:0] intl;
    input [31:0] stamp;
    begin
      rec_byte = 8'h00;
      case (pos)
        `BYTE_SUMMARY_FIRST: rec_byte = 8'h00;
        `BYTE_MODULE_INFO: rec_byte = `MODULE_INFO_VAL;
        `BYTE_RESERVED_C: rec_byte = 8'h00;
        `BYTE_SUMMARY_INT: rec_byte = intl;
        `BYTE_CHANNEL_KIND: rec_byte = `CHANNEL_KIND_AI;
        `BYTE_BITS_PER_CH: rec_byte = `BITS_PER_CH_VAL;
        `BYTE_CHANNEL_COUNT: rec_byte = `CHANNEL_COUNT_VAL;
        `BYTE_GROUP_ERRORS: rec_byte = grp;
        5'd8: rec_byte = faults[7:0];
        5'd9: rec_byte = faults[15:8];
        5'd10: rec_byte = faults[23:16];
        5'd11: rec_byte = faults[31:24];
        // Bytes 12 to 15 stand for absent channels and read zero.
        5'd12: rec_byte = 8'h00;
        5'd13: rec_byte = 8'h00;
        5'd14: rec_byte = 8'h00;
        5'd15: rec_byte = 8'h00;
        5'd16: rec_byte = stamp[7:0];
        5'd17: rec_byte = stamp[15:8];
        5'd18: rec_byte = stamp[23:16];
        5'd19: rec_byte = stamp[31:24];
        default: rec_byte = 8'h00;
      endcase
    end
  endfunction

  // -------------------------------------------------------------------
  // Snapshot store of record bytes 0 to 7, one byte refreshed each cycle
  // -------------------------------------------------------------------
  // The store keeps a rolling copy of bytes 0 to 7, one byte a cycle.
  // Answers come from the live record, so no answer is ever stale.
  reg [4:0] fill_pos_r;
  reg [4:0] rd_pos;

  always @(posedge clk) begin
    if (!rst_b) begin
      fill_pos_r <= 5'd0;
    end else begin
      fill_pos_r <= (fill_pos_r == 5'd7) ? 5'd0 : fill_pos_r + 5'd1;
    end
  end

  diag_byte_store #(.DEPTH(8), .AW(3)) u_store (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(1'b1),
    .wr_addr(fill_pos_r[2:0]),
    .wr_data(rec_byte(fill_pos_r, fault_r, group_r, internal_r, stamp_r)),
    .rd_addr(rd_pos[2:0]),
    .rd_data_r()
  );

  // -------------------------------------------------------------------
  // Request decode
  // -------------------------------------------------------------------
  reg [4:0] len;
  reg [4:0] base;
  reg sel_ok;

  always @* begin
    len = 5'd0;
    base = 5'd0;
    sel_ok = 1'b0;
    rd_pos = 5'd0;
    case (rd_mode)
      // Record set 01h reads the whole record, 00h its first four bytes.
      MODE_RECSET: begin
        if (record_set_number == `REC_SET_FULL) begin
          len = `RECORD_BYTES;
          sel_ok = (rd_byte < `RECORD_BYTES);
        end else if (record_set_number == `REC_SET_FIRST4) begin
          len = `FIRST4_BYTES;
          sel_ok = (rd_byte < `FIRST4_BYTES);
        end
        base = rd_byte;
      end
      // Object index access mirrors the record set access.
      MODE_INDEX: begin
        if (object_index == `OBJ_INDEX_FULL) begin
          len = `RECORD_BYTES;
          sel_ok = (rd_byte < `RECORD_BYTES);
        end else if (object_index == `OBJ_INDEX_FIRST4) begin
          len = `FIRST4_BYTES;
          sel_ok = (rd_byte < `FIRST4_BYTES);
        end
        base = rd_byte;
      end
      // Subindex 02h to 11h maps onto record bytes 0 to 15 one by one.
      MODE_SUBIDX: begin
        if (object_index == `OBJ_INDEX_SUB) begin
          if (object_subindex == `SUBIDX_TIMESTAMP) begin
            len = 5'd4;
            base = `TS_BYTE_POS;
            sel_ok = 1'b1;
          end else if (object_subindex >= `SUBIDX_FIRST &&
                       object_subindex < `SUBIDX_TIMESTAMP - 8'h01) begin
            len = 5'd1;
            base = object_subindex[4:0] - 5'd2;
            sel_ok = 1'b1;
          end
        end
      end
      default: begin
        sel_ok = 1'b0;
      end
    endcase
    rd_pos = base;
  end

  // -------------------------------------------------------------------
  // Answer; one word per request, assembled from the live record
  // -------------------------------------------------------------------
  reg [1:0] state_r;
  reg [31:0] word_nxt;

  always @* begin
    word_nxt = 32'h00000000;
    if (rd_mode == MODE_SUBIDX && base == `TS_BYTE_POS) begin
      word_nxt = stamp_r;
    end else begin
      word_nxt = {24'h000000, rec_byte(base, fault_r, group_r, internal_r,
        stamp_r)};
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      rd_valid_r <= 1'b0;
      rd_error_r <= 1'b0;
      rd_data_r <= 32'h00000000;
      rd_len_r <= 5'd0;
    end else begin
      rd_valid_r <= 1'b0;
      rd_error_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Unknown selectors or bytes beyond the object answer an error.
          if (rd_req) begin
            rd_valid_r <= sel_ok;
            rd_error_r <= !sel_ok;
            rd_data_r <= sel_ok ? word_nxt : 32'h00000000;
            rd_len_r <= sel_ok ? len : 5'd0;
            state_r <= ST_READ;
          end
        end
        // A request in the cycle after a taken one is ignored.
        ST_READ: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== diag_checker.sv
// Port checker of the diagnostic record.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module diag_checker #(
  parameter CHANNELS = 4,
  parameter TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Channel error sources
  input wire logic [CHANNELS-1:0] param_error,
  input wire logic [CHANNELS-1:0] range_underflow,
  input wire logic [CHANNELS-1:0] range_overflow,
  // Indicators
  input wire logic [CHANNELS-1:0] channel_led_r,
  input wire logic diag_irq,
  // Read request and answer
  input wire logic rd_req,
  input wire logic [1:0] rd_mode,
  input wire logic [7:0] record_set_number,
  input wire logic [4:0] rd_byte,
  input wire logic rd_valid_r,
  input wire logic rd_error_r,
  input wire logic [31:0] rd_data_r,
  input wire logic [4:0] rd_len_r,
  input wire logic [31:0] us_timer
);
  // --------
  // Checks
  // --------
  localparam int TMAX = TICK_CYCLES;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  no_irq_a: assert property (diag_irq == 1'b0)
    else $error("diagnostic interrupt raised");
  led_cause_a: assert property (
    channel_led_r == $past(param_error | range_underflow | range_overflow))
    else $error("channel led does not follow errors");
  answer_once_a: assert property (rd_req |=> rd_valid_r ^ rd_error_r)
    else $error("read request not answered once");
  answer_cause_a: assert property (
    !$past(rd_req) |-> !(rd_valid_r || rd_error_r))
    else $error("answer without request");
  first_len_a: assert property (
    rd_valid_r && $past(rd_mode) == 2'h0
    && $past(record_set_number) == 8'h00 |-> rd_len_r == 5'd4)
    else $error("short record length wrong");
  info_byte_a: assert property (
    rd_valid_r && $past(rd_mode) == 2'h0 && $past(rd_byte) == 5'h01
    |-> rd_data_r == 32'h00000015)
    else $error("module information wrong");
  kind_byte_a: assert property (
    rd_valid_r && $past(rd_mode) == 2'h0 && $past(rd_byte) == 5'h04
    |-> rd_data_r == 32'h00000071)
    else $error("channel kind wrong");
  timer_step_a: assert property (
    $changed(us_timer) |-> us_timer == $past(us_timer) + 32'h1)
    else $error("timer step wrong");
  timer_tick_a: assert property (
    $changed(us_timer) |-> ##[1:TMAX] $changed(us_timer))
    else $error("timer stalled");
endmodule

bind analog_input_diagnostic_record diag_checker #(
  .CHANNELS(CHANNELS), .TICK_CYCLES(TICK_CYCLES)) chk_i (
  .clk(clk), .rst_b(rst_b), .param_error(param_error),
  .range_underflow(range_underflow), .range_overflow(range_overflow),
  .channel_led_r(channel_led_r), .diag_irq(diag_irq), .rd_req(rd_req),
  .rd_mode(rd_mode), .record_set_number(record_set_number),
  .rd_byte(rd_byte), .rd_valid_r(rd_valid_r), .rd_error_r(rd_error_r),
  .rd_data_r(rd_data_r), .rd_len_r(rd_len_r), .us_timer(us_timer));
`default_nettype wire

// ===== coupler_model.sv
// Backplane coupler model issuing one read request per command.
// Assumes the bench raises go for one cycle per request.
`timescale 1ns/1ps
`default_nettype none

module coupler_model (
  // Clock
  input wire logic clk,
  // Command from the bench
  input wire logic go,
  input wire logic [1:0] mode,
  input wire logic [15:0] sel,
  input wire logic [4:0] pos,
  // Request to the record
  output logic rd_req,
  output logic [1:0] rd_mode,
  output logic [7:0] record_set_number,
  output logic [15:0] object_index,
  output logic [7:0] object_subindex,
  output logic [4:0] rd_byte
);
  // --------
  // Requester
  // --------
  initial begin
    rd_req = 1'b0;
    {rd_mode, record_set_number, object_index, object_subindex} = '0;
    rd_byte = 5'h00;
  end
  // Selectors are inverted once taken, so stale values are never seen.
  always @(posedge clk) begin
    rd_req <= go;
    if (go) begin
      rd_mode <= mode;
      record_set_number <= sel[7:0];
      object_index <= (mode == 2'h2) ? 16'h5005 : sel;
      object_subindex <= sel[7:0];
      rd_byte <= pos;
    end else if (rd_req) begin
      rd_mode <= ~rd_mode;
      record_set_number <= ~record_set_number;
      object_index <= ~object_index;
      object_subindex <= ~object_subindex;
      rd_byte <= ~rd_byte;
    end
  end
endmodule
`default_nettype wire

// ===== tb_analog_input_diagnostic_record.sv
// Bench of the diagnostic record, read through the coupler model.
// Assumes the record, its store, the model and the checker.
`timescale 1ns/1ps
`default_nettype none

module tb_analog_input_diagnostic_record;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic go = 1'b0;
  logic bo = 1'b0;
  logic ce = 1'b0;
  logic [3:0] pe = 4'h0;
  logic [3:0] un = 4'h0;
  logic [3:0] ov = 4'h0;
  logic [1:0] md = 2'h0;
  logic [15:0] sl = 16'h0000;
  logic [4:0] ps = 5'h00;
  wire rq, irq, vld, er, mel;
  wire [1:0] rm;
  wire [7:0] rs, rx;
  wire [15:0] ri;
  wire [4:0] rb, len;
  wire [3:0] led;
  wire [31:0] dat, tmr;
  logic [7:0] tab [0:11] = '{8'h00, 8'h15, 8'h00, 8'h18, 8'h71, 8'h08,
    8'h04, 8'h07, 8'h01, 8'h40, 8'h80, 8'h00};
  logic [31:0] t;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  coupler_model cm (
    .clk(clk), .go(go), .mode(md), .sel(sl), .pos(ps), .rd_req(rq),
    .rd_mode(rm), .record_set_number(rs), .object_index(ri),
    .object_subindex(rx), .rd_byte(rb));
  analog_input_diagnostic_record dut (
    .clk(clk), .rst_b(rst_b), .param_error(pe), .range_underflow(un),
    .range_overflow(ov), .int_buffer_overflow(bo), .int_comm_error(ce),
    .channel_led_r(led), .module_error_led_r(mel), .diag_irq(irq),
    .rd_req(rq), .rd_mode(rm), .record_set_number(rs), .object_index(ri),
    .object_subindex(rx), .rd_byte(rb), .rd_valid_r(vld), .rd_error_r(er),
    .rd_data_r(dat), .rd_len_r(len), .us_timer(tmr));

  // --------
  // Tasks
  // --------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task close_out;
    $display("mismatches %0d in %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One read; checks the error flag and, if good, the data.
  task q(input logic [1:0] m, input logic [15:0] s, input logic [4:0] p,
    input logic ee, input logic [31:0] ed);
    int k;
    @(posedge clk);
    md <= m;
    sl <= s;
    ps <= p;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    #1;
    while (vld !== 1'b1 && er !== 1'b1 && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 8) err_count++;
    chk("error flag", {31'h0, er}, {31'h0, ee});
    if (!ee) chk("read data", dat, ed);
  endtask

  task sweep(input logic f);
    logic [7:0] e;
    for (int i = 0; i < 12; i++) begin
      e = tab[i];
      if (!f && (i == 3 || i > 6)) e = 8'h00;
      q(2'h0, 16'h0001, i[4:0], 1'b0, {24'h0, e});
    end
    chk("length", {27'h0, len}, 32'd20);
  endtask

  // --------
  // Run
  // --------
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk("timer", tmr, 32'h0);
    chk("module led", {31'h0, mel}, 32'h0);
    sweep(1'b0);
    t = tmr;
    while (tmr === t) begin
      @(posedge clk);
      #1;
    end
    t = tmr;
    @(posedge clk);
    pe <= 4'h1;
    un <= 4'h2;
    ov <= 4'h4;
    bo <= 1'b1;
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("led", {28'h0, led}, 32'h7);
    chk("module led", {31'h0, mel}, 32'h1);
    sweep(1'b1);
    q(2'h2, 16'h0013, 5'h00, 1'b0, t);
    q(2'h0, 16'h0001, 5'h10, 1'b0, {24'h0, t[7:0]});
    q(2'h0, 16'h0000, 5'h01, 1'b0, 32'h15);
    chk("length", {27'h0, len}, 32'd4);
    q(2'h0, 16'h0000, 5'h04, 1'b1, 32'h0);
    q(2'h1, 16'h2F01, 5'h04, 1'b0, 32'h71);
    q(2'h1, 16'h2F00, 5'h05, 1'b1, 32'h0);
    q(2'h2, 16'h0003, 5'h00, 1'b0, 32'h15);
    chk("length", {27'h0, len}, 32'd1);
    q(2'h2, 16'h000A, 5'h00, 1'b0, 32'h01);
    q(2'h2, 16'h0011, 5'h00, 1'b0, 32'h0);
    q(2'h2, 16'h0012, 5'h00, 1'b1, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
